// ===== verilog/isr_status_top.v
`timescale 1ns/1ps
`include "isr_defs.vh"
module isr_status_top (
  input  wire        core_clk,
  input  wire        srst,
  input  wire        constantVoltageFlag,
  input  wire        constantCurrentFlag,
  input  wire        faultFreeFlag,
  input  wire        dcSeqTriggerWait,
  input  wire        powerUpRunOn,
  input  wire        emergencyHaltArmed,
  input  wire        dcSeqStepActive,
  input  wire        operatorControlMode,
  input  wire        acUndervoltGuardOn,
  input  wire        interlockArmed,
  input  wire        runPermitArmed,
  input  wire        currentFoldbackOn,
  input  wire        extVoltageRef,
  input  wire        currentProtectMode,
  input  wire        stairSeqTriggerWait,
  input  wire        burstSeqTriggerWait,
  input  wire        tableSeqTriggerWait,
  input  wire        burstSeqRunning,
  input  wire        tableSeqRunning,
  input  wire        voltageFoldbackOn,
  input  wire        interlockTripped,
  input  wire        runPermitAsserted,
  input  wire        dcUndervoltGuardOn,
  input  wire        mixedUndervoltGuardOn,
  input  wire        settingsInvalid,
  input  wire        hostCmdValid,
  input  wire [3:0]  hostCmdCode,
  input  wire [31:0] hostCmdData,
  input  wire        errLogValid,
  input  wire [15:0] errLogCode,
  input  wire        parseMissingParam,
  input  wire        parseWrongCount,
  input  wire        parseBadSuffix,
  input  wire        linkWatchdogExpired,
  input  wire        linkChecksumBad,
  input  wire        linkRxOverrun,
  output wire        hostRespValid,
  output wire [31:0] hostRespData,
  output wire        hostRespEmpty,
  output wire [7:0]  statusByte,
  output wire        errLogReady
);
  reg  [31:0] condSnap_q;
  reg  [31:0] condPrev_q;
  reg  [31:0] opEn_q;
  reg  [31:0] opEvt_q;
  reg  [7:0]  stdEn_q;
  reg  [7:0]  stdEvt_q;
  reg  [7:0]  statusByte_q;
  reg         respValid_q;
  reg  [31:0] respData_q;
  reg         respEmpty_q;
  reg         opcSet_q;
  reg         booted_q;
  reg         logReady_q;
  reg  [15:0] genCode_q;
  reg  [9:0]  pend_q;
  reg  [9:0]  pend_d;
  reg  [9:0]  pendNew;
  reg  [9:0]  pendSel;
  reg  [15:0] logCode;
  reg         logValid;
  reg  [31:0] qData;
  reg         isQuery;
  reg         isKnown;
  reg  [31:0] condLive;
  reg  [31:0] opEvt_d;
  reg  [7:0]  stdSet;
  reg  [7:0]  stdEvt_d;
  integer     i;
  wire [15:0] errHead;
  wire [3:0]  errCount;
  wire [31:0] outHead;
  wire        outFull;
  wire        outEmpty;
  wire [3:0]  cmd = hostCmdCode;
  wire        queryOk   = hostCmdValid && isQuery && !outFull;
  wire        queryDrop = hostCmdValid && isQuery && outFull;
  wire        clsCmd    = hostCmdValid && (cmd == `ISR_CMD_CLS);
  wire        msgRead   = hostCmdValid && (cmd == `ISR_CMD_MSG_RD);

  // code range to standard event bit
  function [7:0] errClass;
    input [15:0] code;
    reg signed [15:0] c;
    begin
      c        = code;
      errClass = 8'h00;
      if (c <= -16'sd100 && c >= -16'sd199) begin
        errClass[`ISR_SE_CME] = 1'b1;
      end else if (c <= -16'sd200 && c >= -16'sd299) begin
        errClass[`ISR_SE_EXE] = 1'b1;
      end else if ((c <= -16'sd300 && c >= -16'sd399) ||
                   (c >= 16'sd1 && c <= $signed(`ISR_EC_DDE_MAX))) begin
        errClass[`ISR_SE_DDE] = 1'b1;
      end else if (c <= -16'sd400 && c >= -16'sd499) begin
        errClass[`ISR_SE_QYE] = 1'b1;
      end
    end
  endfunction

  function [15:0] srcCode;
    input [3:0] idx;
    begin
      case (idx)
        4'd1:    srcCode = `ISR_EC_MISSPAR;
        4'd2:    srcCode = `ISR_EC_PARCNT;
        4'd3:    srcCode = `ISR_EC_SUFFIX;
        4'd4:    srcCode = `ISR_EC_WDOG;
        4'd5:    srcCode = `ISR_EC_CHKSUM;
        4'd6:    srcCode = `ISR_EC_RXOVR;
        4'd7:    srcCode = `ISR_EC_SETTINGS;
        4'd8:    srcCode = `ISR_EC_CMD;
        4'd9:    srcCode = `ISR_EC_OUTOVR;
        default: srcCode = `ISR_EC_NONE;
      endcase
    end
  endfunction

  always @* begin
    condLive = 32'h0000_0000;
    condLive[`ISR_OP_CV]     = constantVoltageFlag;
    condLive[`ISR_OP_CC]     = constantCurrentFlag;
    condLive[`ISR_OP_FAULT_FREE_FLAG]   = faultFreeFlag;
    condLive[`ISR_OP_DCTW]   = dcSeqTriggerWait;
    condLive[`ISR_OP_PURUN]  = powerUpRunOn;
    condLive[`ISR_OP_EHALT]  = emergencyHaltArmed;
    condLive[`ISR_OP_DCSTEP] = dcSeqStepActive;
    condLive[`ISR_OP_OPMODE] = operatorControlMode;
    condLive[`ISR_OP_ACUV]   = acUndervoltGuardOn;
    condLive[`ISR_OP_ILARM]  = interlockArmed;
    condLive[`ISR_OP_RPARM]  = runPermitArmed;
    condLive[`ISR_OP_CFOLD]  = currentFoldbackOn;
    condLive[`ISR_OP_EXTREF] = extVoltageRef;
    condLive[`ISR_OP_CPROT]  = currentProtectMode;
    condLive[`ISR_OP_STTW]   = stairSeqTriggerWait;
    condLive[`ISR_OP_BSTW]   = burstSeqTriggerWait;
    condLive[`ISR_OP_TBTW]   = tableSeqTriggerWait;
    condLive[`ISR_OP_BSRUN]  = burstSeqRunning;
    condLive[`ISR_OP_TBRUN]  = tableSeqRunning;
    condLive[`ISR_OP_VFOLD]  = voltageFoldbackOn;
    condLive[`ISR_OP_ILTRIP] = interlockTripped;
    condLive[`ISR_OP_RPACT]  = runPermitAsserted;
    condLive[`ISR_OP_DCUV]   = dcUndervoltGuardOn;
    condLive[`ISR_OP_MIXUV]  = mixedUndervoltGuardOn;
  end

  // command decode and query answer
  always @* begin
    isQuery = 1'b0;
    isKnown = 1'b1;
    qData   = 32'h0000_0000;
    case (cmd)
      `ISR_CMD_OPCOND_Q: begin
        isQuery = 1'b1;
        qData   = condSnap_q;
      end
      `ISR_CMD_OPEN_Q: begin
        isQuery = 1'b1;
        qData   = opEn_q;
      end
      `ISR_CMD_OPEV_Q: begin
        isQuery = 1'b1;
        qData   = opEvt_q;
      end
      `ISR_CMD_SEEN_Q: begin
        isQuery = 1'b1;
        qData   = {24'h00_0000, stdEn_q};
      end
      `ISR_CMD_SEEV_Q: begin
        isQuery = 1'b1;
        qData   = {24'h00_0000, stdEvt_q};
      end
      `ISR_CMD_STB_Q: begin
        isQuery = 1'b1;
        qData   = {24'h00_0000, statusByte_q};
      end
      `ISR_CMD_ERR_Q: begin
        isQuery = 1'b1;
        qData   = {{16{errHead[15]}}, errHead};
      end
      `ISR_CMD_OPEN_W, `ISR_CMD_SEEN_W, `ISR_CMD_CLS, `ISR_CMD_MSG_RD: begin
        isQuery = 1'b0;
      end
      default: begin
        isKnown = 1'b0;
      end
    endcase
  end

  // error sources wait in sticky pending bits; one is logged per cycle
  always @* begin
    pendNew    = 10'h000;
    pendNew[0] = errLogValid && !pend_q[0];
    pendNew[1] = parseMissingParam;
    pendNew[2] = parseWrongCount;
    pendNew[3] = parseBadSuffix;
    pendNew[4] = linkWatchdogExpired;
    pendNew[5] = linkChecksumBad;
    pendNew[6] = linkRxOverrun;
    pendNew[7] = !booted_q && settingsInvalid;
    pendNew[8] = hostCmdValid && !isKnown;
    pendNew[9] = queryDrop;
    pendSel  = 10'h000;
    logValid = 1'b0;
    logCode  = `ISR_EC_NONE;
    for (i = 9; i >= 0; i = i - 1) begin
      if (pend_q[i]) begin
        pendSel  = 10'h000;
        pendSel[i] = 1'b1;
        logValid = 1'b1;
        logCode  = (i == 0) ? genCode_q : srcCode(i[3:0]);
      end
    end
    // a new event on the bit being retired is kept, except on bit 0
    pend_d = (pend_q & ~pendSel) | pendNew;
  end

  // event latching: set wins over the read clear
  always @* begin
    opEvt_d = opEvt_q;
    if (queryOk && cmd == `ISR_CMD_OPEV_Q) begin
      opEvt_d = 32'h0000_0000;
    end
    // rising edges only, else a standing condition re-sets after every read
    opEvt_d = (opEvt_d | (condSnap_q & ~condPrev_q & opEn_q)) & `ISR_OP_MASK;
    stdSet = 8'h00;
    if (logValid) begin
      stdSet = errClass(logCode);
    end
    stdSet[`ISR_SE_OPC] = opcSet_q;
    stdSet[`ISR_SE_PON] = !booted_q;
    stdEvt_d = stdEvt_q;
    if (queryOk && cmd == `ISR_CMD_SEEV_Q) begin
      stdEvt_d = 8'h00;
    end
    stdEvt_d = (stdEvt_d | stdSet) & `ISR_SE_MASK;
  end

  always @(posedge core_clk) begin
    if (srst) begin
      condSnap_q   <= `ISR_RESET_ZERO;
      condPrev_q   <= `ISR_RESET_ZERO;
      opEn_q       <= `ISR_RESET_ZERO;
      opEvt_q      <= `ISR_RESET_ZERO;
      stdEn_q      <= 8'h00;
      stdEvt_q     <= 8'h00;
      statusByte_q <= 8'h00;
      respValid_q  <= 1'b0;
      respData_q   <= `ISR_RESET_ZERO;
      respEmpty_q  <= 1'b0;
      opcSet_q     <= 1'b0;
      booted_q     <= 1'b0;
      genCode_q    <= 16'h0000;
      pend_q       <= 10'h000;
      logReady_q   <= 1'b1;
    end else begin
      condSnap_q <= condLive & `ISR_OP_MASK;
      condPrev_q <= condSnap_q;
      opEvt_q    <= opEvt_d;
      stdEvt_q   <= stdEvt_d;
      booted_q   <= 1'b1;
      pend_q     <= pend_d;
      logReady_q <= !pend_d[0];
      opcSet_q   <= hostCmdValid && isKnown && !queryDrop;
      if (pendNew[0]) begin
        genCode_q <= errLogCode;
      end
      if (hostCmdValid && cmd == `ISR_CMD_OPEN_W) begin
        opEn_q <= hostCmdData & `ISR_OP_MASK;
      end
      if (hostCmdValid && cmd == `ISR_CMD_SEEN_W) begin
        stdEn_q <= hostCmdData[7:0] & `ISR_SE_MASK;
      end
      statusByte_q <= 8'h00;
      statusByte_q[`ISR_SB_ESB] <= |(stdEvt_q & stdEn_q);
      statusByte_q[`ISR_SB_MAV] <= !outEmpty;
      statusByte_q[`ISR_SB_ERR] <= (errCount != 4'h0);
      respValid_q <= msgRead;
      if (msgRead) begin
        respData_q  <= outEmpty ? `ISR_RESET_ZERO : outHead;
        respEmpty_q <= outEmpty;
      end
    end
  end

  isr_err_fifo u_errq (
    .core_clk (core_clk),
    .srst     (srst),
    .push     (logValid),
    .pushCode (logCode),
    .pop      (queryOk && cmd == `ISR_CMD_ERR_Q),
    .clr      (clsCmd),
    .headCode (errHead),
    .count    (errCount)
  );

  isr_out_queue u_outq (
    .core_clk (core_clk),
    .srst     (srst),
    .push     (queryOk),
    .pushData (qData),
    .pop      (msgRead),
    .clr      (clsCmd),
    .headData (outHead),
    .full     (outFull),
    .empty    (outEmpty)
  );

  assign hostRespValid = respValid_q;
  assign hostRespData  = respData_q;
  assign hostRespEmpty = respEmpty_q;
  assign statusByte    = statusByte_q;
  assign errLogReady   = logReady_q;
endmodule

// ===== verilog/isr_defs.vh
`ifndef ISR_DEFS_VH
`define ISR_DEFS_VH
// operational condition bit positions
`define ISR_OP_CV        0
`define ISR_OP_CC        1
`define ISR_OP_FAULT_FREE_FLAG      2
`define ISR_OP_DCTW      3
`define ISR_OP_PURUN     4
`define ISR_OP_EHALT     5
`define ISR_OP_DCSTEP    6
`define ISR_OP_OPMODE    7
`define ISR_OP_ACUV      8
`define ISR_OP_ILARM     9
`define ISR_OP_RPARM     10
`define ISR_OP_CFOLD     11
`define ISR_OP_EXTREF    12
`define ISR_OP_CPROT     13
`define ISR_OP_STTW      16
`define ISR_OP_BSTW      17
`define ISR_OP_TBTW      18
`define ISR_OP_BSRUN     19
`define ISR_OP_TBRUN     20
`define ISR_OP_VFOLD     21
`define ISR_OP_ILTRIP    23
`define ISR_OP_RPACT     24
`define ISR_OP_DCUV      25
`define ISR_OP_MIXUV     26
`define ISR_OP_MASK      32'h07BF_3FFF
// standard event bit positions
`define ISR_SE_OPC       0
`define ISR_SE_QYE       2
`define ISR_SE_DDE       3
`define ISR_SE_EXE       4
`define ISR_SE_CME       5
`define ISR_SE_PON       7
`define ISR_SE_MASK      8'hBD
// status byte bit positions
`define ISR_SB_ERR       2
`define ISR_SB_MAV       4
`define ISR_SB_ESB       5
// host command codes
`define ISR_CMD_OPCOND_Q 4'h0
`define ISR_CMD_OPEN_W   4'h1
`define ISR_CMD_OPEN_Q   4'h2
`define ISR_CMD_OPEV_Q   4'h3
`define ISR_CMD_SEEN_W   4'h4
`define ISR_CMD_SEEN_Q   4'h5
`define ISR_CMD_SEEV_Q   4'h6
`define ISR_CMD_STB_Q    4'h7
`define ISR_CMD_CLS      4'h8
`define ISR_CMD_ERR_Q    4'h9
`define ISR_CMD_MSG_RD   4'hA
// error codes, 16-bit two's complement
`define ISR_EC_NONE      16'h0000
`define ISR_EC_CMD       16'hFF9C
`define ISR_EC_MISSPAR   16'hFF93
`define ISR_EC_PARCNT    16'hFF8D
`define ISR_EC_SUFFIX    16'hFF7D
`define ISR_EC_OVERFLOW  16'hFEA2
`define ISR_EC_WDOG      16'hFE98
`define ISR_EC_CHKSUM    16'hFE97
`define ISR_EC_RXOVR     16'hFE95
`define ISR_EC_SETTINGS  16'h0001
`define ISR_EC_OUTOVR    16'h000C
`define ISR_EC_DDE_MAX   16'h7FFA
// queue sizes and the reset value
`define ISR_ERRQ_DEPTH   4'hA
`define ISR_ERRQ_LAST    4'h9
`define ISR_OUTQ_DEPTH   3'h4
`define ISR_RESET_ZERO   32'h0000_0000
`endif

// ===== verilog/isr_err_fifo.v
`timescale 1ns/1ps
`include "isr_defs.vh"
module isr_err_fifo (
  input  wire        core_clk,
  input  wire        srst,
  input  wire        push,
  input  wire [15:0] pushCode,
  input  wire        pop,
  input  wire        clr,
  output wire [15:0] headCode,
  output wire [3:0]  count
);
  reg [15:0] mem [0:9];
  reg [3:0]  wrPtr_q;
  reg [3:0]  rdPtr_q;
  reg [3:0]  count_q;
  wire       doPop  = pop && (count_q != 4'h0);
  wire       isFull = (count_q == `ISR_ERRQ_DEPTH);
  wire       doPush = push && (!isFull || doPop);
  wire       ovf    = push && isFull && !doPop;
  wire [3:0] lastIdx = (wrPtr_q == 4'h0) ? `ISR_ERRQ_LAST : wrPtr_q - 4'h1;

  function [3:0] nextIdx;
    input [3:0] idx;
    begin
      nextIdx = (idx == `ISR_ERRQ_LAST) ? 4'h0 : idx + 4'h1;
    end
  endfunction

  always @(posedge core_clk) begin
    if (srst || clr) begin
      wrPtr_q <= 4'h0;
      rdPtr_q <= 4'h0;
      count_q <= 4'h0;
      // an error logged together with the clear survives it
      if (!srst && push) begin
        mem[4'h0] <= pushCode;
        wrPtr_q   <= 4'h1;
        count_q   <= 4'h1;
      end
    end else begin
      if (doPush) begin
        mem[wrPtr_q] <= pushCode;
        wrPtr_q      <= nextIdx(wrPtr_q);
      end
      if (ovf) begin
        mem[lastIdx] <= `ISR_EC_OVERFLOW;
      end
      if (doPop) begin
        rdPtr_q <= nextIdx(rdPtr_q);
      end
      if (doPush && !doPop) begin
        count_q <= count_q + 4'h1;
      end else if (doPop && !doPush) begin
        count_q <= count_q - 4'h1;
      end
    end
  end

  // empty queue answers code 0
  assign headCode = (count_q == 4'h0) ? `ISR_EC_NONE : mem[rdPtr_q];
  assign count    = count_q;
endmodule

// ===== verilog/isr_out_queue.v
`timescale 1ns/1ps
`include "isr_defs.vh"
module isr_out_queue (
  input  wire        core_clk,
  input  wire        srst,
  input  wire        push,
  input  wire [31:0] pushData,
  input  wire        pop,
  input  wire        clr,
  output wire [31:0] headData,
  output wire        full,
  output wire        empty
);
  reg [31:0] mem [0:3];
  reg [1:0]  wrPtr_q;
  reg [1:0]  rdPtr_q;
  reg [2:0]  count_q;
  wire       doPop  = pop && (count_q != 3'h0);
  wire       doPush = push && (count_q != `ISR_OUTQ_DEPTH);

  always @(posedge core_clk) begin
    if (srst || clr) begin
      wrPtr_q <= 2'h0;
      rdPtr_q <= 2'h0;
      count_q <= 3'h0;
    end else begin
      if (doPush) begin
        mem[wrPtr_q] <= pushData;
        wrPtr_q      <= wrPtr_q + 2'h1;
      end
      if (doPop) begin
        rdPtr_q <= rdPtr_q + 2'h1;
      end
      if (doPush && !doPop) begin
        count_q <= count_q + 3'h1;
      end else if (doPop && !doPush) begin
        count_q <= count_q - 3'h1;
      end
    end
  end

  assign headData = mem[rdPtr_q];
  assign full     = (count_q == `ISR_OUTQ_DEPTH);
  assign empty    = (count_q == 3'h0);
endmodule

// ===== sim/isr_status_asserts.sv
`timescale 1ns/1ps
`include "isr_defs.vh"
module isr_status_asserts (
  input wire        core_clk,
  input wire        srst,
  input wire        hostCmdValid,
  input wire [3:0]  hostCmdCode,
  input wire [31:0] hostCmdData,
  input wire        errLogValid,
  input wire        errLogReady,
  input wire        hostRespValid,
  input wire [31:0] hostRespData,
  input wire        hostRespEmpty,
  input wire [7:0]  statusByte
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  wire msgRd  = hostCmdValid && hostCmdCode == `ISR_CMD_MSG_RD;
  wire anyQry = hostCmdValid && (hostCmdCode inside {4'h0, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h9});
  wire maskWr = hostCmdValid && hostCmdCode == `ISR_CMD_SEEN_W;
  // no command may pop or clear while the new entry travels to the flag
  sequence s_errlog;
    errLogValid && errLogReady && !hostCmdValid ##1 !hostCmdValid [*3];
  endsequence
  sequence s_mask_off;
    maskWr && hostCmdData[7:0] == 8'h00 ##1 !maskWr;
  endsequence
  sequence s_query_alone;
    anyQry && !statusByte[`ISR_SB_MAV] ##1 !hostCmdValid;
  endsequence
  property p_sb_spare;
    (statusByte & 8'hCB) == 8'h00;
  endproperty
  property p_resp_cause;
    hostRespValid |-> $past(msgRd);
  endproperty
  property p_resp_follow;
    msgRd |=> hostRespValid;
  endproperty
  property p_empty_zero;
    hostRespValid && hostRespEmpty |-> hostRespData == 32'h0000_0000;
  endproperty
  property p_reset_clean;
    $fell(srst) |-> statusByte == 8'h00 && !hostRespValid && errLogReady;
  endproperty
  property p_err_flag;
    s_errlog |-> statusByte[`ISR_SB_ERR];
  endproperty
  property p_esb_off;
    s_mask_off |=> !statusByte[`ISR_SB_ESB];
  endproperty
  property p_mav_set;
    s_query_alone |=> statusByte[`ISR_SB_MAV];
  endproperty
  a_sb_spare: assert property (p_sb_spare)
    else $error("status byte spare bit set");
  a_resp_cause: assert property (p_resp_cause)
    else $error("response without message read");
  a_resp_follow: assert property (p_resp_follow)
    else $error("message read not answered");
  a_empty_zero: assert property (p_empty_zero)
    else $error("empty response carries data");
  a_reset_clean: assert property (p_reset_clean)
    else $error("outputs not clean after reset");
  a_err_flag: assert property (p_err_flag)
    else $error("error pending flag missing");
  a_esb_off: assert property (p_esb_off)
    else $error("summary bit set with mask cleared");
  a_mav_set: assert property (p_mav_set)
    else $error("message available flag missing");
endmodule
bind isr_status_top isr_status_asserts u_asserts (
  .core_clk(core_clk), .srst(srst), .hostCmdValid(hostCmdValid),
  .hostCmdCode(hostCmdCode), .hostCmdData(hostCmdData), .errLogValid(errLogValid),
  .errLogReady(errLogReady), .hostRespValid(hostRespValid), .hostRespData(hostRespData),
  .hostRespEmpty(hostRespEmpty), .statusByte(statusByte)
);

// ===== sim/isr_host_model.sv
`timescale 1ns/1ps
`include "isr_defs.vh"
module isr_host_model (
  input  wire        core_clk,
  output reg         hostCmdValid,
  output reg  [3:0]  hostCmdCode,
  output reg  [31:0] hostCmdData,
  input  wire        hostRespValid,
  input  wire [31:0] hostRespData,
  input  wire        hostRespEmpty
);
  initial begin
    hostCmdValid = 1'b0;
    hostCmdCode = 4'hF;
    hostCmdData = 32'hA5A5_A5A5;
  end
  task send(input [3:0] code, input [31:0] data);
    @(negedge core_clk);
    hostCmdValid = 1'b1;
    hostCmdCode = code;
    hostCmdData = data;
    @(negedge core_clk);
    hostCmdValid = 1'b0;
    // released lines flip so stale values never look like a command
    hostCmdCode = ~code;
    hostCmdData = ~data;
  endtask
  task fetch(output [31:0] data, output empty, output got);
    integer i;
    send(`ISR_CMD_MSG_RD, 32'h0000_0000);
    got = 1'b0;
    data = 32'h0000_0000;
    empty = 1'b0;
    for (i = 0; i < 4 && !got; i = i + 1) begin
      if (hostRespValid === 1'b1) begin
        got = 1'b1;
        data = hostRespData;
        empty = hostRespEmpty;
      end
      else @(negedge core_clk);
    end
  endtask
endmodule

// ===== sim/instrument_status_reporting_test.sv
`timescale 1ns/1ps
`include "isr_defs.vh"
module instrument_status_reporting_test;
  reg         core_clk = 1'b0;
  reg         srst = 1'b1;
  reg         settingsInvalid = 1'b1;
  reg  [23:0] cond = 24'h00_0000;
  reg  [5:0]  srcs = 6'h00;
  reg         errLogValid = 1'b0;
  reg  [15:0] errLogCode = 16'h0000;
  wire        hostCmdValid, hostRespValid, hostRespEmpty, errLogReady;
  wire [3:0]  hostCmdCode;
  wire [31:0] hostCmdData, hostRespData;
  wire [7:0]  statusByte;
  integer     mismatches = 0;
  integer     n_compared = 0;
  integer     i;
  integer     srcCode [0:5] = '{-109, -115, -131, -360, -361, -363};
  int         eq[$];
  reg  [7:0]  se = 8'h88;
  reg  [7:0]  seEn = 8'h00;
  reg  [31:0] d, v, x32, opEn, opEv;
  reg         e, g;
  always #12.5 core_clk = ~core_clk;
  isr_status_top dut (
    .core_clk(core_clk), .srst(srst), .constantVoltageFlag(cond[0]),
    .constantCurrentFlag(cond[1]), .faultFreeFlag(cond[2]), .dcSeqTriggerWait(cond[3]),
    .powerUpRunOn(cond[4]), .emergencyHaltArmed(cond[5]), .dcSeqStepActive(cond[6]),
    .operatorControlMode(cond[7]), .acUndervoltGuardOn(cond[8]), .interlockArmed(cond[9]),
    .runPermitArmed(cond[10]), .currentFoldbackOn(cond[11]), .extVoltageRef(cond[12]),
    .currentProtectMode(cond[13]), .stairSeqTriggerWait(cond[14]),
    .burstSeqTriggerWait(cond[15]), .tableSeqTriggerWait(cond[16]),
    .burstSeqRunning(cond[17]), .tableSeqRunning(cond[18]), .voltageFoldbackOn(cond[19]),
    .interlockTripped(cond[20]), .runPermitAsserted(cond[21]),
    .dcUndervoltGuardOn(cond[22]), .mixedUndervoltGuardOn(cond[23]),
    .settingsInvalid(settingsInvalid), .hostCmdValid(hostCmdValid),
    .hostCmdCode(hostCmdCode), .hostCmdData(hostCmdData), .errLogValid(errLogValid),
    .errLogCode(errLogCode), .parseMissingParam(srcs[0]), .parseWrongCount(srcs[1]),
    .parseBadSuffix(srcs[2]), .linkWatchdogExpired(srcs[3]), .linkChecksumBad(srcs[4]),
    .linkRxOverrun(srcs[5]), .hostRespValid(hostRespValid), .hostRespData(hostRespData),
    .hostRespEmpty(hostRespEmpty), .statusByte(statusByte), .errLogReady(errLogReady)
  );
  isr_host_model host (
    .core_clk(core_clk), .hostCmdValid(hostCmdValid), .hostCmdCode(hostCmdCode),
    .hostCmdData(hostCmdData), .hostRespValid(hostRespValid),
    .hostRespData(hostRespData), .hostRespEmpty(hostRespEmpty)
  );
  function [31:0] opMap(input [23:0] c);
    opMap = {5'h00, c[23:20], 1'h0, c[19:14], 2'h0, c[13:0]};
  endfunction
  function [7:0] sbx(input mav);
    sbx = {2'h0, |(se & seEn), mav, 1'h0, eq.size() != 0, 2'h0};
  endfunction
  task give_verdict;
    if (mismatches == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task chkSb(input mav);
    check("status byte", {24'h0, statusByte}, {24'h0, sbx(mav)});
  endtask
  task note(input integer c);
    if (eq.size() < 10) eq.push_back(c);
    else eq[9] = -350;
    se[c > 0 ? 3 : c > -200 ? 5 : c > -300 ? 4 : c > -400 ? 3 : 2] = 1'b1;
  endtask
  task wr(input [3:0] c, input [31:0] data);
    host.send(c, data);
    se = se | 8'h01;
    repeat (3) @(negedge core_clk);
  endtask
  task query(input [3:0] c);
    host.send(c, 32'h0000_0000);
    host.fetch(d, e, g);
    check("response", {31'h0, g}, 32'h0000_0001);
    se = se | 8'h01;
    repeat (4) @(negedge core_clk);
  endtask
  task esr;
    x32 = {24'h0, se};
    query(`ISR_CMD_SEEV_Q);
    check("std events", d, x32);
    // the message read after the clear sets completion again
    se = 8'h01;
  endtask
  task drain(input integer n);
    repeat (n) begin
      x32 = eq.size() ? eq.pop_front() : 0;
      query(`ISR_CMD_ERR_Q);
      check("error entry", d, x32);
    end
  endtask
  task pulse(input integer k, input integer c);
    @(negedge core_clk);
    if (k < 6) srcs = 6'h01 << k;
    else begin
      check("log ready", {31'h0, errLogReady}, 32'h0000_0001);
      errLogValid = 1'b1;
      errLogCode = c[15:0];
    end
    @(negedge core_clk);
    srcs = 6'h00;
    errLogValid = 1'b0;
    note(c);
    repeat (3) @(negedge core_clk);
  endtask
  initial begin
    repeat (6000) @(posedge core_clk);
    mismatches = mismatches + 1;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h5fd1));
    repeat (10) @(negedge core_clk);
    srst = 1'b0;
    @(negedge core_clk);
    settingsInvalid = 1'b0;
    eq.push_back(1);
    repeat (4) @(negedge core_clk);
    chkSb(0);
    esr();
    esr();
    for (i = 0; i < 2; i = i + 1) begin
      v = i ? $urandom : 32'h0000_0000;
      wr(`ISR_CMD_SEEN_W, v);
      seEn = v[7:0] & `ISR_SE_MASK;
      query(`ISR_CMD_SEEN_Q);
      check("std enable", d, {24'h0, seEn});
      chkSb(0);
    end
    for (i = 0; i < 4; i = i + 1) begin
      v = $urandom;
      wr(`ISR_CMD_OPEN_W, v);
      opEn = v & `ISR_OP_MASK;
      query(`ISR_CMD_OPEN_Q);
      check("op enable", d, opEn);
      v = $urandom;
      cond = v[23:0];
      repeat (3) @(negedge core_clk);
      opEv = opMap(cond) & opEn;
      query(`ISR_CMD_OPCOND_Q);
      check("op condition", d, opMap(cond));
      // condition gone before the read: the latch must still hold it
      cond = 24'h00_0000;
      repeat (3) @(negedge core_clk);
      query(`ISR_CMD_OPEV_Q);
      check("op events", d, opEv);
      query(`ISR_CMD_OPEV_Q);
      check("op events", d, 32'h0000_0000);
    end
    for (i = 0; i < 11; i = i + 1) begin
      if (i < 6) pulse(i, srcCode[i]);
      else if (i == 10) pulse(i, 1 + int'($urandom_range(32761)));
      else pulse(i, -100 * (i - 5) - int'($urandom_range(99)));
    end
    host.send(4'hB, 32'h0000_0000);
    note(-100);
    repeat (4) @(negedge core_clk);
    esr();
    drain(11);
    chkSb(0);
    v = $urandom;
    cond = v[23:0] | 24'h00_0001;
    repeat (3) @(negedge core_clk);
    repeat (5) host.send(`ISR_CMD_OPCOND_Q, 32'h0000_0000);
    note(12);
    repeat (4) @(negedge core_clk);
    chkSb(1);
    for (i = 0; i < 5; i = i + 1) begin
      host.fetch(d, e, g);
      check("queued word", d, i < 4 ? opMap(cond) : 32'h0000_0000);
      check("queue empty", {31'h0, e}, {31'h0, i == 4});
    end
    repeat (4) @(negedge core_clk);
    drain(1);
    host.send(`ISR_CMD_OPCOND_Q, 32'h0000_0000);
    pulse(6, -222);
    chkSb(1);
    wr(`ISR_CMD_CLS, 32'h0000_0000);
    eq.delete();
    chkSb(0);
    query(`ISR_CMD_STB_Q);
    check("status query", d, {24'h0, sbx(0)});
    give_verdict();
  end
endmodule
